// file: dtr_diode_model.sv
`timescale 1ns/1ps
module dtr_diode_model import dtr_pkg::*; #(
  parameter logic [9:0] BASE = 10'h040,
  parameter logic [9:0] DELTA_ONE = 10'h3e7,
  parameter logic [9:0] DELTA_TWO = 10'h064
) (
  // Bias and select from the readout
  input wire logic bias_high,
  input wire logic diode_sel_two,
  // Reading back
  output dtr_sample_s diode_sample
);
  // One code more every other pair, so the mean sits on a half degree
  logic wobble = 1'b0;
  logic [9:0] delta;
  always @(negedge bias_high)
    wobble <= ~wobble;
  assign delta = diode_sel_two ? DELTA_TWO : DELTA_ONE;
  assign diode_sample = {1'b1, BASE + (bias_high ? delta + {9'h0, wobble} : 10'h0)};
endmodule : dtr_diode_model

// file: dtr_pkg.sv
package dtr_pkg;
  // Register byte addresses (printed offsets are not all multiples of four: index x4)
  localparam logic [7:0] DTR_IDX_INT_TEMP = 8'h27;
  localparam logic [7:0] DTR_IDX_TEMP_CFG = 8'h4b;
  localparam logic [11:0] DTR_ADDR_INT_TEMP = 12'h09c;
  localparam logic [11:0] DTR_ADDR_TEMP_CFG = 12'h12c;
  // Own registers
  localparam logic [11:0] DTR_ADDR_CHAN_MODE = 12'h200;
  localparam logic [11:0] DTR_ADDR_REMOTE1 = 12'h204;
  localparam logic [11:0] DTR_ADDR_REMOTE2 = 12'h208;
  localparam logic [11:0] DTR_ADDR_CTRL = 12'h20c;
  localparam int DTR_ADDR_W = 12;
  localparam logic [7:0] DTR_CHAN_MODE_RST = 8'h00;
  localparam int DTR_CM_D2_BIT = 2;
  localparam int DTR_CFG_FRAC_LO = 6;
  localparam int DTR_CTRL_START_BIT = 0;
  localparam int DTR_AVG_N = 16;
  localparam int DTR_AVG_SHIFT = 4;
  localparam int DTR_ACC_W = 12;
  localparam int DTR_CLK_MHZ = 100;
  localparam int DTR_MEAS_TIME_US_X10 = 96000;
  localparam int DTR_MEAS_CYCLES = DTR_MEAS_TIME_US_X10 * DTR_CLK_MHZ / 10;
  localparam int DTR_STEP_CYCLES = DTR_MEAS_CYCLES / (2 * DTR_AVG_N);
  localparam logic [1:0] DTR_RESP_OKAY = 2'b00;
  localparam logic [1:0] DTR_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {DTR_CH_INT, DTR_CH_R1, DTR_CH_R2} dtr_chan_e;
  typedef enum logic [1:0] {DTR_ST_IDLE, DTR_ST_LOW, DTR_ST_HIGH} dtr_state_e;

  // Converter sample handed in from the analog front end
  typedef struct packed {
    logic valid;
    logic [9:0] code;
  } dtr_sample_s;
endpackage : dtr_pkg

// file: dtr_readout.sv
`timescale 1ns/1ps
module dtr_readout import dtr_pkg::*; #(
  parameter int MEAS_CYCLES = DTR_MEAS_CYCLES,
  parameter int STEP_CYCLES = DTR_STEP_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [DTR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [DTR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter front end: on-chip sensor result, quarter degrees, signed
  input wire dtr_sample_s int_sample,
  // Converter front end: remote diode reading, signed, degrees
  input wire dtr_sample_s diode_sample,
  // Bias and channel select to the diode front end
  output logic bias_high,
  output logic diode_sel_two,
  output logic shared_pins_diode,
  output logic meas_busy
);
  logic [7:0] chan_mode_q;
  logic run_q;
  logic [7:0] int_temp_q;
  logic [1:0] int_frac_q;
  logic [5:0] cfg_low_q;
  logic [7:0] rem1_q;
  logic [7:0] rem2_q;
  logic aw_have_q, w_have_q;
  logic [DTR_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  dtr_state_e st_q;
  dtr_chan_e ch_q;
  logic [31:0] tmr_q;
  logic [4:0] cyc_q;
  logic signed [9:0] low_q;
  logic signed [DTR_ACC_W-1:0] acc_q;
  logic signed [DTR_ACC_W-1:0] acc_sum;
  logic signed [DTR_ACC_W-1:0] acc_avg;
  logic step_done;
  logic wr_fire;

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    wr_byte = s[0] ? d[7:0] : old;
  endfunction : wr_byte

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  // Write response and writable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= DTR_RESP_OKAY;
      chan_mode_q <= DTR_CHAN_MODE_RST;
      run_q <= 1'b0;
      cfg_low_q <= '0;
    end
    else
    begin
      if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= DTR_RESP_OKAY;
        unique case (awaddr_q[DTR_ADDR_W-1:2])
          DTR_ADDR_CHAN_MODE[DTR_ADDR_W-1:2]: chan_mode_q <= wr_byte(chan_mode_q, wdata_q, wstrb_q);
          DTR_ADDR_TEMP_CFG[DTR_ADDR_W-1:2]:
          begin
            // Fraction bits are read-only; only the low six bits are stored
            if (wstrb_q[0])
              cfg_low_q <= wdata_q[5:0];
          end
          DTR_ADDR_CTRL[DTR_ADDR_W-1:2]:
          begin
            if (wstrb_q[0])
              run_q <= wdata_q[DTR_CTRL_START_BIT];
          end
          DTR_ADDR_INT_TEMP[DTR_ADDR_W-1:2], DTR_ADDR_REMOTE1[DTR_ADDR_W-1:2],
          DTR_ADDR_REMOTE2[DTR_ADDR_W-1:2]: bresp_q <= DTR_RESP_OKAY;
          default: bresp_q <= DTR_RESP_SLVERR;
        endcase
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= DTR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= DTR_RESP_OKAY;
      rdata_q <= '0;
      unique case (s_axi_araddr[DTR_ADDR_W-1:2])
        DTR_ADDR_INT_TEMP[DTR_ADDR_W-1:2]: rdata_q[7:0] <= int_temp_q;
        DTR_ADDR_TEMP_CFG[DTR_ADDR_W-1:2]: rdata_q[7:0] <= {int_frac_q, cfg_low_q};
        DTR_ADDR_CHAN_MODE[DTR_ADDR_W-1:2]: rdata_q[7:0] <= chan_mode_q;
        DTR_ADDR_REMOTE1[DTR_ADDR_W-1:2]: rdata_q[7:0] <= rem1_q;
        DTR_ADDR_REMOTE2[DTR_ADDR_W-1:2]: rdata_q[7:0] <= rem2_q;
        DTR_ADDR_CTRL[DTR_ADDR_W-1:2]: rdata_q[1:0] <= {meas_busy, run_q};
        default: rresp_q <= DTR_RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // On-chip sensor: integer degrees in two's complement, quarter degrees in the fraction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_temp_q <= '0;
      int_frac_q <= '0;
    end
    else if (int_sample.valid)
    begin
      int_temp_q <= int_sample.code[9:2];
      int_frac_q <= int_sample.code[1:0];
    end
  end

  assign step_done = (tmr_q >= 32'(STEP_CYCLES - 1));
  assign acc_sum = acc_q + DTR_ACC_W'(diode_sample.code - low_q);
  assign acc_avg = acc_sum >>> DTR_AVG_SHIFT;
  assign bias_high = (st_q == DTR_ST_HIGH);
  // Gated by the mode bit so the shared pins are never biased once handed back
  assign diode_sel_two = (ch_q == DTR_CH_R2) && chan_mode_q[DTR_CM_D2_BIT];
  assign shared_pins_diode = chan_mode_q[DTR_CM_D2_BIT];
  assign meas_busy = (st_q != DTR_ST_IDLE);

  // Remote sequencer: 16 low/high bias pairs spread evenly over one measurement
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= DTR_ST_IDLE;
      ch_q <= DTR_CH_R1;
      tmr_q <= '0;
      cyc_q <= '0;
      low_q <= '0;
      acc_q <= '0;
      rem1_q <= '0;
      rem2_q <= '0;
    end
    else if (ch_q == DTR_CH_R2 && !shared_pins_diode)
    begin
      // Pins returned to voltage use mid-measurement: the partial result is dropped
      st_q <= run_q ? DTR_ST_LOW : DTR_ST_IDLE;
      ch_q <= DTR_CH_R1;
      tmr_q <= '0;
      cyc_q <= '0;
      acc_q <= '0;
    end
    else
    begin
      unique case (st_q)
        DTR_ST_IDLE:
        begin
          tmr_q <= '0;
          cyc_q <= '0;
          acc_q <= '0;
          if (run_q)
            st_q <= DTR_ST_LOW;
        end
        DTR_ST_LOW:
        begin
          tmr_q <= step_done ? '0 : tmr_q + 32'd1;
          if (step_done)
          begin
            low_q <= signed'(diode_sample.code);
            st_q <= DTR_ST_HIGH;
          end
        end
        DTR_ST_HIGH:
        begin
          tmr_q <= step_done ? '0 : tmr_q + 32'd1;
          if (step_done)
          begin
            if (cyc_q == 5'(DTR_AVG_N - 1))
            begin
              // Truncating shift keeps the lower code for half-degree steps
              if (ch_q == DTR_CH_R2)
                rem2_q <= acc_avg[7:0];
              else
                rem1_q <= acc_avg[7:0];
              acc_q <= '0;
              cyc_q <= '0;
              if (ch_q == DTR_CH_R1 && shared_pins_diode)
                ch_q <= DTR_CH_R2;
              else
                ch_q <= DTR_CH_R1;
              st_q <= run_q ? DTR_ST_LOW : DTR_ST_IDLE;
            end
            else
            begin
              acc_q <= acc_sum;
              cyc_q <= cyc_q + 5'd1;
              st_q <= DTR_ST_LOW;
            end
          end
        end
        default: st_q <= DTR_ST_IDLE;
      endcase
    end
  end
endmodule : dtr_readout

// file: dtr_readout_props.sv
`timescale 1ns/1ps
module dtr_readout_props import dtr_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Front end control
  input wire logic bias_high,
  input wire logic diode_sel_two,
  input wire logic shared_pins_diode,
  input wire logic meas_busy
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("second write taken");
  a_sel_needs_mode: assert property (diode_sel_two |-> shared_pins_diode)
    else $error("second diode used as voltage input");
  a_bias_in_meas: assert property (bias_high |-> meas_busy)
    else $error("high bias outside measurement");
  a_mode_reset: assert property ($rose(aresetn) |-> !shared_pins_diode)
    else $error("shared pins not voltage after reset");
endmodule : dtr_readout_props

bind dtr_readout dtr_readout_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .bias_high(bias_high),
  .diode_sel_two(diode_sel_two), .shared_pins_diode(shared_pins_diode), .meas_busy(meas_busy));

// file: tb_dtr_readout.sv
`timescale 1ns/1ps
module tb_dtr_readout import dtr_pkg::*; ;
  localparam int STEP = 4;
  localparam int MEAS = 2 * DTR_AVG_N * STEP;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdata;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wrr, bv, arr, rv, bias, sel2, spd, busy;
  logic [1:0] bresp, rresp;
  dtr_sample_s ints = '0;
  dtr_sample_s dio;
  logic [9:0] codes [3] = '{10'h39e, 10'h1ff, 10'h200};
  logic [7:0] ints_x [3] = '{8'he7, 8'h7f, 8'h80};
  logic [1:0] frac_x [3] = '{2'h2, 2'h3, 2'h0};
  int err_total = 0, checks_done = 0, cyc = 0;
  int hi_len = 0;
  logic lazy = 1'b0;
  always #5 aclk = ~aclk;
  dtr_readout #(.STEP_CYCLES(STEP)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .int_sample(ints), .diode_sample(dio), .bias_high(bias), .diode_sel_two(sel2),
    .shared_pins_diode(spd), .meas_busy(busy));
  dtr_diode_model u_diode (.bias_high(bias), .diode_sel_two(sel2), .diode_sample(dio));
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    // Every other call of wr and rdc together holds bready back so the response has to wait
    br <= !lazy;
    forever
    begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wrr)
        wv <= 1'b0;
      if (bv && br)
        break;
      br <= bv || !lazy;
    end
    chk({32'h0, bresp}, {32'h0, er});
    br <= 1'b0;
    lazy = !lazy;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [1:0] er, input logic [31:0] e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    // Every other call of wr and rdc together holds rready back so the read data has to stand
    rr <= !lazy;
    forever
    begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
      if (rv && rr)
        break;
      rr <= rv || !lazy;
    end
    chk({rresp, rdata}, {er, e});
    rr <= 1'b0;
    lazy = !lazy;
  endtask : rdc
  // Every high-bias phase lasts exactly one step
  always @(posedge aclk)
  begin
    if (bias)
      hi_len++;
    else if (hi_len != 0)
    begin
      chk(34'(hi_len), 34'(STEP));
      hi_len = 0;
    end
  end
  // A hang costs one mismatch and still reaches the verdict
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(DTR_ADDR_CHAN_MODE, DTR_RESP_OKAY, 32'h0);
    chk({33'h0, spd}, 34'h0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge aclk);
      ints <= {1'b1, codes[i]};
      @(posedge aclk);
      ints.valid <= 1'b0;
      wr(DTR_ADDR_TEMP_CFG, 32'h15, DTR_RESP_OKAY);
      rdc(DTR_ADDR_INT_TEMP, DTR_RESP_OKAY, {24'h0, ints_x[i]});
      rdc(DTR_ADDR_TEMP_CFG, DTR_RESP_OKAY, {24'h0, frac_x[i], 6'h15});
    end
    wr(DTR_ADDR_INT_TEMP, 32'h55, DTR_RESP_OKAY);
    rdc(DTR_ADDR_INT_TEMP, DTR_RESP_OKAY, 32'h80);
    rdc(12'h300, DTR_RESP_SLVERR, 32'h0);
    wr(12'h300, 32'h1, DTR_RESP_SLVERR);
    wr(DTR_ADDR_CTRL, 32'h1, DTR_RESP_OKAY);
    rdc(DTR_ADDR_CTRL, DTR_RESP_OKAY, 32'h3);
    repeat (3 * MEAS) @(posedge aclk);
    rdc(DTR_ADDR_REMOTE1, DTR_RESP_OKAY, 32'he7);
    rdc(DTR_ADDR_REMOTE2, DTR_RESP_OKAY, 32'h0);
    wr(DTR_ADDR_CHAN_MODE, 32'h4, DTR_RESP_OKAY);
    chk({33'h0, spd}, 34'h1);
    repeat (4 * MEAS) @(posedge aclk);
    rdc(DTR_ADDR_REMOTE2, DTR_RESP_OKAY, 32'h64);
    rdc(DTR_ADDR_REMOTE1, DTR_RESP_OKAY, 32'he7);
    wr(DTR_ADDR_CHAN_MODE, 32'h0, DTR_RESP_OKAY);
    chk({33'h0, sel2}, 34'h0);
    wr(DTR_ADDR_CTRL, 32'h0, DTR_RESP_OKAY);
    repeat (MEAS + 8) @(posedge aclk);
    rdc(DTR_ADDR_CTRL, DTR_RESP_OKAY, 32'h0);
    chk({33'h0, bias}, 34'h0);
    give_verdict();
  end
endmodule : tb_dtr_readout
